// *** hw/evt_pkg.sv ***
// Constants, register map and event codes for the transfer event manager.
// Assumes a single 125 MHz clock domain and an AXI4-Lite register bus.
package evt_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYCLES = TICK_S * CLK_HZ;
  localparam logic [6:0] SYNC_LIMIT_S = 7'd120;
  localparam logic [15:0] SAVE_PERIOD_S = 16'd43200;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_TIMEOUT = 12'h004;
  localparam logic [11:0] OFS_ACTIVE = 12'h008;
  localparam logic [11:0] OFS_CURRENT = 12'h00c;
  localparam logic [11:0] OFS_HIST_IDX = 12'h010;
  localparam logic [11:0] OFS_HIST_DATA = 12'h014;
  localparam logic [11:0] OFS_SEQ = 12'h018;
  localparam logic [11:0] OFS_NTHRESH = 12'h01c;
  localparam logic [11:0] OFS_CLOCK = 12'h020;
  localparam logic [11:0] OFS_STATUS = 12'h024;

  // CTRL fields and reset values
  localparam int CTRL_FALLBACK = 0;
  localparam int CTRL_LOADMON = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [15:0] TIMEOUT_RST = 16'h0a0a;
  localparam logic [15:0] NTHRESH_RST = 16'hffff;

  // ****************************************************************
  // Event codes and record layout
  // ****************************************************************
  localparam int NUM_EV = 22;
  localparam int EV_LOCKOUT = 0;
  localparam int EV_FAIL_XFER = 1;
  localparam int EV_FAIL_REXFER = 2;
  localparam int EV_CONTACT = 3;
  localparam int EV_PWR_LOSS = 7;
  localparam int EV_EMERG = 8;
  localparam int EV_SYNC_FAIL = 9;
  localparam int EV_GEN_ALARM = 10;
  localparam int EV_WINK = 11;
  localparam int EV_NEUTRAL = 12;
  localparam int EV_MOTOR_DISC = 13;
  localparam int EV_SEQ = 14;
  localparam int NUM_FAULT_EV = 7;
  // Contact fault order inside the 4-bit group
  localparam int CF_P_CLOSE = 0;
  localparam int CF_P_OPEN = 1;
  localparam int CF_A_CLOSE = 2;
  localparam int CF_A_OPEN = 3;

  localparam int REC_ACK = 31;
  localparam int REC_ID_LSB = 26;
  localparam int STAMP_W = 26;
  localparam logic [5:0] HIST_DEPTH = 6'd50;

  // ****************************************************************
  // Synchronised pin positions
  // ****************************************************************
  localparam int NUM_PIN = 12;
  localparam int PIN_POS_P = 0;
  localparam int PIN_POS_A = 1;
  localparam int PIN_XFER = 2;
  localparam int PIN_REXFER = 3;
  localparam int PIN_SYNC_ACT = 4;
  localparam int PIN_MATCHED = 5;
  localparam int PIN_GEN_ALARM = 6;
  localparam int PIN_MOTOR_DISC = 7;
  localparam int PIN_RESET_BTN = 8;
  localparam int PIN_PWR_LOSS = 9;
  localparam int PIN_WINK = 10;
  localparam int PIN_NEED_GEN = 11;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : evt_pkg

// *** hw/transfer_event_manager.sv ***
// Event supervision, display and 50-entry history for a transfer switch.
// Assumes pins are asynchronous to aclk; neutral current comes from
// metering logic on aclk; software owns the AXI4-Lite registers.
//
// Behaviour
// - Events are fault or non-fault, active or inactive
// - Records hold id, time stamp, pending-acknowledge marker
// - Reset press acknowledges all, moves display to history
// - Newer event displaces older, which goes unacknowledged
// - History holds 50; oldest dropped when full
// - Save record twice daily and on power loss
// - Any contact fault raises lockout
// - Transfer open/close time limits latch failure
// - Retransfer open/close time limits latch failure
// - Primary close failure, then lockout
// - Primary open failure, then lockout
// - Alternate close failure, then lockout
// - Alternate open failure, then lockout
// - Signal shutdown, finish sequences, then power off
// - Emergency start held while generator needed
// - Sync failure after 120 s, held until reset
// - After sync failure fall back or retry
// - Generator alarm input makes alarm event active
// - Eight sequencer outputs, announce on change
// - Network write activates identify event and message
// - Neutral current above threshold raises warning
// - Motor disconnect event, mechanism not driven
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
module transfer_event_manager #(
  parameter int unsigned tick_cycles = evt_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins from mechanism, panel and network module
  input wire logic [evt_pkg::NUM_PIN-1:0] pins,
  // Metering
  input wire logic [15:0] neutral_amps,
  // Outputs
  output logic drive_en,
  output logic emerg_start,
  output logic sync_fail_relay,
  output logic open_transition,
  output logic shutdown_notice,
  output logic power_off,
  output logic save_req,
  output logic announce,
  output logic [7:0] seq_out,
  output logic disp_valid,
  output logic [4:0] disp_id,
  output logic disp_ack_pending,
  output logic wink_msg
);

  // ****************************************************************
  // Pin synchronisers and edges
  // ****************************************************************
  logic [evt_pkg::NUM_PIN-1:0] meta_q, pin_q, pin_prev_q;
  always_ff @(posedge aclk)
  begin
    meta_q <= pins;
    pin_q <= meta_q;
    pin_prev_q <= aresetn ? pin_q : '0;
  end
  wire [evt_pkg::NUM_PIN-1:0] pin_rise = pin_q & ~pin_prev_q;
  wire rst_press = pin_rise[evt_pkg::PIN_RESET_BTN];
  wire mdisc = pin_q[evt_pkg::PIN_MOTOR_DISC];

  // ****************************************************************
  // One-second tick, clock, twice-daily save
  // ****************************************************************
  logic [31:0] tick_cnt_q;
  logic tick_q;
  logic [25:0] clock_q;
  logic [15:0] save_cnt_q;
  wire tick_wrap = tick_cnt_q == 32'(tick_cycles - 1);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
      save_cnt_q <= '0;
    end
    else
    begin
      tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + 32'd1;
      tick_q <= tick_wrap;
      if (tick_q)
        save_cnt_q <= (save_cnt_q == evt_pkg::SAVE_PERIOD_S - 16'd1) ?
                      '0 : save_cnt_q + 16'd1;
    end
  end

  // ****************************************************************
  // Register file state
  // ****************************************************************
  logic [1:0] ctrl_q;
  logic [15:0] timeout_q, nthresh_q;
  logic [7:0] seq_q;
  logic [5:0] hidx_q;
  wire [7:0] open_to = timeout_q[7:0];
  wire [7:0] close_to = timeout_q[15:8];

  // ****************************************************************
  // Transfer supervision
  // ****************************************************************
  typedef enum logic [2:0] {
    MV_IDLE, MV_X_OPEN, MV_X_CLOSE, MV_R_OPEN, MV_R_CLOSE
  } move_e;
  move_e mv_q, mv_d;
  logic [7:0] mv_sec_q;
  logic [3:0] contact_q, contact_set;
  logic fail_xfer_q, fail_rexfer_q, lockout_q;
  wire [7:0] mv_limit = (mv_q == MV_X_OPEN || mv_q == MV_R_OPEN) ?
                        open_to : close_to;
  wire mv_over = tick_q && (mv_sec_q + 8'd1 >= mv_limit);
  wire pos_p = pin_q[evt_pkg::PIN_POS_P];
  wire pos_a = pin_q[evt_pkg::PIN_POS_A];

  always_comb
  begin
    mv_d = mv_q;
    contact_set = '0;
    unique case (mv_q)
      MV_IDLE:
        if (!lockout_q && !mdisc && pin_rise[evt_pkg::PIN_XFER] && pos_p)
          mv_d = MV_X_OPEN;
        else if (!lockout_q && !mdisc && pin_rise[evt_pkg::PIN_REXFER] && pos_a)
          mv_d = MV_R_OPEN;
      MV_X_OPEN:
        if (!pos_p)
          mv_d = MV_X_CLOSE;
        else if (mv_over)
        begin
          contact_set[evt_pkg::CF_P_OPEN] = 1'b1;
          mv_d = MV_IDLE;
        end
      MV_X_CLOSE:
        if (pos_a)
          mv_d = MV_IDLE;
        else if (mv_over)
        begin
          contact_set[evt_pkg::CF_A_CLOSE] = 1'b1;
          mv_d = MV_IDLE;
        end
      MV_R_OPEN:
        if (!pos_a)
          mv_d = MV_R_CLOSE;
        else if (mv_over)
        begin
          contact_set[evt_pkg::CF_A_OPEN] = 1'b1;
          mv_d = MV_IDLE;
        end
      MV_R_CLOSE:
        if (pos_p)
          mv_d = MV_IDLE;
        else if (mv_over)
        begin
          contact_set[evt_pkg::CF_P_CLOSE] = 1'b1;
          mv_d = MV_IDLE;
        end
    endcase
  end
  wire xfer_fail_set = (mv_q == MV_X_OPEN || mv_q == MV_X_CLOSE) &&
                       (|contact_set);
  wire rexfer_fail_set = (mv_q == MV_R_OPEN || mv_q == MV_R_CLOSE) &&
                         (|contact_set);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mv_q <= MV_IDLE;
      mv_sec_q <= '0;
      contact_q <= '0;
      fail_xfer_q <= 1'b0;
      fail_rexfer_q <= 1'b0;
      lockout_q <= 1'b0;
      drive_en <= 1'b0;
    end
    else
    begin
      mv_q <= mv_d;
      mv_sec_q <= (mv_d != mv_q) ? '0 : mv_sec_q + {7'd0, tick_q};
      contact_q <= contact_set | (contact_q & {4{~rst_press}});
      fail_xfer_q <= xfer_fail_set | (fail_xfer_q & ~rst_press);
      fail_rexfer_q <= rexfer_fail_set | (fail_rexfer_q & ~rst_press);
      lockout_q <= ((|contact_q) | lockout_q) & ~rst_press;
      drive_en <= (mv_d != MV_IDLE) && !mdisc && !lockout_q;
    end
  end

  // ****************************************************************
  // Sync check, power loss, other event sources
  // ****************************************************************
  logic [6:0] sync_sec_q;
  logic sync_fail_q, wink_q, neutral_q;
  wire sync_wait = pin_q[evt_pkg::PIN_SYNC_ACT] && !pin_q[evt_pkg::PIN_MATCHED];
  wire sync_hit = sync_wait && tick_q &&
                  (sync_sec_q == evt_pkg::SYNC_LIMIT_S - 7'd1);
  wire pwr_loss = pin_q[evt_pkg::PIN_PWR_LOSS];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_sec_q <= '0;
      sync_fail_q <= 1'b0;
      wink_q <= 1'b0;
      neutral_q <= 1'b0;
      shutdown_notice <= 1'b0;
      power_off <= 1'b0;
      save_req <= 1'b0;
      emerg_start <= 1'b0;
    end
    else
    begin
      // Counter restarts after a failure so retries can fail again
      sync_sec_q <= (!sync_wait || sync_hit) ? '0 :
                    sync_sec_q + {6'd0, tick_q};
      sync_fail_q <= sync_hit | (sync_fail_q & ~rst_press);
      wink_q <= pin_rise[evt_pkg::PIN_WINK] | (wink_q & ~rst_press);
      neutral_q <= ctrl_q[evt_pkg::CTRL_LOADMON] &&
                   (neutral_amps > nthresh_q);
      shutdown_notice <= pwr_loss;
      power_off <= pwr_loss && shutdown_notice && mv_q == MV_IDLE;
      save_req <= pin_rise[evt_pkg::PIN_PWR_LOSS] ||
                  (tick_q && save_cnt_q == evt_pkg::SAVE_PERIOD_S - 16'd1);
      emerg_start <= pin_q[evt_pkg::PIN_NEED_GEN];
    end
  end
  assign sync_fail_relay = sync_fail_q;
  assign wink_msg = wink_q;
  assign seq_out = seq_q;

  // ****************************************************************
  // Event vector, pending queue, display
  // ****************************************************************
  // Bits below NUM_FAULT_EV are fault events, the rest non-fault
  wire [evt_pkg::NUM_EV-1:0] ev_act = {seq_q, mdisc, neutral_q, wink_q,
    pin_q[evt_pkg::PIN_GEN_ALARM], sync_fail_q, emerg_start, pwr_loss,
    contact_q, fail_rexfer_q, fail_xfer_q, lockout_q};
  logic [evt_pkg::NUM_EV-1:0] ev_prev_q, pend_q;

  function automatic logic [4:0] first_set(
    input logic [evt_pkg::NUM_EV-1:0] v
  );
    logic [4:0] r;
    r = '0;
    for (int i = evt_pkg::NUM_EV - 1; i >= 0; i--)
      if (v[i])
        r = 5'(i);
    return r;
  endfunction : first_set

  wire take = (|pend_q) && !rst_press;
  wire [4:0] take_id = first_set(pend_q);
  logic [25:0] cur_stamp_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ev_prev_q <= '0;
      pend_q <= '0;
      disp_valid <= 1'b0;
      disp_id <= '0;
      disp_ack_pending <= 1'b0;
      cur_stamp_q <= '0;
    end
    else
    begin
      ev_prev_q <= ev_act;
      pend_q <= (ev_act & ~ev_prev_q) |
                (pend_q & ~({{(evt_pkg::NUM_EV-1){1'b0}}, take} << take_id));
      if (rst_press)
      begin
        disp_valid <= 1'b0;
        disp_ack_pending <= 1'b0;
      end
      else if (take)
      begin
        disp_valid <= 1'b1;
        disp_id <= take_id;
        disp_ack_pending <= 1'b1;
        cur_stamp_q <= clock_q;
      end
    end
  end

  // ****************************************************************
  // History store
  // ****************************************************************
  logic [30:0] hist_mem [evt_pkg::HIST_DEPTH];
  logic [49:0] hack_q;
  logic [5:0] wr_ptr_q, hcount_q;
  wire push = disp_valid && (take || rst_press);
  wire [5:0] wr_next = (wr_ptr_q == evt_pkg::HIST_DEPTH - 6'd1) ?
                       '0 : wr_ptr_q + 6'd1;

  function automatic logic [5:0] hist_slot(input logic [5:0] wp,
                                           input logic [5:0] idx);
    logic [6:0] s;
    s = {1'b0, wp} + {1'b0, evt_pkg::HIST_DEPTH} - 7'd1 - {1'b0, idx};
    if (s >= {1'b0, evt_pkg::HIST_DEPTH})
      s = s - {1'b0, evt_pkg::HIST_DEPTH};
    return s[5:0];
  endfunction : hist_slot

  always_ff @(posedge aclk)
  begin
    if (push)
      hist_mem[wr_ptr_q] <= {disp_id, cur_stamp_q};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr_q <= '0;
      hcount_q <= '0;
      hack_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_next;
        if (hcount_q != evt_pkg::HIST_DEPTH)
          hcount_q <= hcount_q + 6'd1;
      end
      for (int i = 0; i < 50; i++)
        if (push && 6'(i) == wr_ptr_q)
          hack_q[i] <= !rst_press && disp_ack_pending;
        else if (rst_press)
          hack_q[i] <= 1'b0;
    end
  end
  wire [5:0] rd_slot = hist_slot(wr_ptr_q, hidx_q);
  wire [31:0] hist_word = (hidx_q < hcount_q) ?
                          {hack_q[rd_slot], hist_mem[rd_slot]} : '0;

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q, w_have_q;

  function automatic logic reg_known(input logic [11:0] a);
    return a inside {evt_pkg::OFS_CTRL, evt_pkg::OFS_TIMEOUT,
      evt_pkg::OFS_ACTIVE, evt_pkg::OFS_CURRENT, evt_pkg::OFS_HIST_IDX,
      evt_pkg::OFS_HIST_DATA, evt_pkg::OFS_SEQ, evt_pkg::OFS_NTHRESH,
      evt_pkg::OFS_CLOCK, evt_pkg::OFS_STATUS};
  endfunction : reg_known

  wire do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                       {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire wr_seq = do_wr && awaddr_q == evt_pkg::OFS_SEQ;
  wire [7:0] seq_d = wr_seq ? ((seq_q & ~wmask[7:0]) |
                     (wdata_q[7:0] & wmask[7:0])) : seq_q;
  wire [31:0] rd_word =
    (s_axi_araddr == evt_pkg::OFS_CTRL) ? {30'd0, ctrl_q} :
    (s_axi_araddr == evt_pkg::OFS_TIMEOUT) ? {16'd0, timeout_q} :
    (s_axi_araddr == evt_pkg::OFS_ACTIVE) ? {10'd0, ev_act} :
    (s_axi_araddr == evt_pkg::OFS_CURRENT) ?
      {disp_ack_pending, disp_id, cur_stamp_q} :
    (s_axi_araddr == evt_pkg::OFS_HIST_IDX) ? {26'd0, hidx_q} :
    (s_axi_araddr == evt_pkg::OFS_HIST_DATA) ? hist_word :
    (s_axi_araddr == evt_pkg::OFS_SEQ) ? {24'd0, seq_q} :
    (s_axi_araddr == evt_pkg::OFS_NTHRESH) ? {16'd0, nthresh_q} :
    (s_axi_araddr == evt_pkg::OFS_CLOCK) ? {6'd0, clock_q} :
    (s_axi_araddr == evt_pkg::OFS_STATUS) ?
      {17'd0, disp_valid, power_off, open_transition, hcount_q,
       3'd0, mv_q} : '0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= evt_pkg::RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= evt_pkg::RESP_OKAY;
      s_axi_rdata <= '0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      ctrl_q <= evt_pkg::CTRL_RST;
      timeout_q <= evt_pkg::TIMEOUT_RST;
      nthresh_q <= evt_pkg::NTHRESH_RST;
      seq_q <= '0;
      hidx_q <= '0;
      clock_q <= '0;
      announce <= 1'b0;
      open_transition <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_known(awaddr_q) ? evt_pkg::RESP_OKAY :
                       evt_pkg::RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (do_wr && awaddr_q == evt_pkg::OFS_CTRL)
        ctrl_q <= (ctrl_q & ~wmask[1:0]) | (wdata_q[1:0] & wmask[1:0]);
      if (do_wr && awaddr_q == evt_pkg::OFS_TIMEOUT)
        timeout_q <= (timeout_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
      if (do_wr && awaddr_q == evt_pkg::OFS_NTHRESH)
        nthresh_q <= (nthresh_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
      if (do_wr && awaddr_q == evt_pkg::OFS_HIST_IDX && wstrb_q[0])
        hidx_q <= wdata_q[5:0];
      if (do_wr && awaddr_q == evt_pkg::OFS_CLOCK && (&wstrb_q))
        clock_q <= wdata_q[25:0];
      else
        clock_q <= clock_q + {25'd0, tick_q};
      seq_q <= seq_d;
      announce <= seq_d != seq_q;
      open_transition <= sync_fail_q && ctrl_q[evt_pkg::CTRL_FALLBACK];
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= reg_known(s_axi_araddr) ? evt_pkg::RESP_OKAY :
                       evt_pkg::RESP_DECERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_lockout_follows: assert property (
    (|contact_q) && !rst_press |=> lockout_q)
    else $error("contact fault without lockout");
  a_xfer_fail_cause: assert property (
    $rose(fail_xfer_q) |-> $past(mv_q == MV_X_OPEN || mv_q == MV_X_CLOSE))
    else $error("transfer failure outside transfer");
  a_rexfer_fail_cause: assert property (
    $rose(fail_rexfer_q) |-> $past(mv_q == MV_R_OPEN || mv_q == MV_R_CLOSE))
    else $error("retransfer failure outside retransfer");
  a_press_clears: assert property (
    rst_press |=> !disp_valid && hack_q == '0)
    else $error("reset press did not clear display");
  a_new_shown: assert property (
    take |=> disp_valid && disp_ack_pending && disp_id == $past(take_id))
    else $error("new event not displayed");
  a_hist_bound: assert property (
    hcount_q <= evt_pkg::HIST_DEPTH && wr_ptr_q < evt_pkg::HIST_DEPTH)
    else $error("history overflow");
  a_sync_hold: assert property (
    sync_fail_q && !rst_press |=> sync_fail_q)
    else $error("sync failure dropped without reset");
  a_seq_announce: assert property (
    seq_q != $past(seq_q) |-> announce)
    else $error("sequencer change not announced");
  a_motor_no_drive: assert property (
    mdisc |=> !drive_en)
    else $error("mechanism driven while disconnected");
  a_off_order: assert property (
    $rose(power_off) |-> $past(shutdown_notice && mv_q == MV_IDLE, 1))
    else $error("power off before shutdown notice");

  c_transfer_done: cover property (mv_q == MV_X_CLOSE ##1 mv_q == MV_IDLE);
  c_hist_full: cover property (hcount_q == evt_pkg::HIST_DEPTH && push);
  c_sync_fail: cover property ($rose(sync_fail_q));
  c_displace: cover property (take && disp_valid);

endmodule : transfer_event_manager

// *** verif/mech_model.sv ***
// Transfer mechanism: leaves its source, rests in neutral, closes the other.
// Assumes drive_en from the design; stuck freezes the contacts.
module mech_model
(
  // Clock
  input wire logic aclk,
  // Control
  input wire logic drive_en,
  input wire logic stuck,
  // Position
  output logic pos_p,
  output logic pos_a
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q = 4'h0;
  logic from_p_q = 1'b1;
  initial pos_p = 1'b1;
  initial pos_a = 1'b0;
  always @(posedge aclk)
    if (!drive_en || stuck)
      cnt_q <= 4'h0;
    else
    begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == 4'h0)
        from_p_q <= pos_p;
      if (cnt_q == 4'h3)
        {pos_p, pos_a} <= 2'b00;
      if (cnt_q == 4'h6)
        {pos_p, pos_a} <= {~from_p_q, from_p_q};
    end
endmodule : mech_model

// *** verif/testbench.sv ***
// Self-checking bench for the transfer event manager.
// Assumes mech_model on the position pins and a 10-cycle tick.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] aw = 12'h000, ar = 12'h000, pv = 12'h000;
  logic [31:0] wd = 32'h0, r, rd_q;
  logic awv = 1'b0, wv = 1'b0, br = 1'b1, arv = 1'b0, rr = 1'b1;
  logic [15:0] amps = 16'h0000;
  logic stuck = 1'b0;
  logic awy, wy, bv, ary, rv, pos_p, pos_a, drv, emg, sfr, opt, ann, dv, dap;
  logic sdn, poff, sav, wnk;
  logic [1:0] bresp, rresp;
  logic [7:0] seq;
  logic [4:0] did;
  int fail_count = 0, checks_done = 0, seed = 13, n, k, anns = 0;
  always #4 aclk = ~aclk;
  always @(posedge aclk) if (ann === 1'b1) anns++;
  mech_model i_mech (.aclk(aclk), .drive_en(drv), .stuck(stuck),
    .pos_p(pos_p), .pos_a(pos_a));
  transfer_event_manager #(.tick_cycles(10)) i_dut (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ar),
    .s_axi_arvalid(arv), .s_axi_arready(ary), .s_axi_rdata(rd_q),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .pins({pv[11:2], pos_a, pos_p}), .neutral_amps(amps), .drive_en(drv),
    .emerg_start(emg), .sync_fail_relay(sfr), .open_transition(opt),
    .shutdown_notice(sdn), .power_off(poff), .save_req(sav),
    .announce(ann), .seq_out(seq), .disp_valid(dv), .disp_id(did),
    .disp_ack_pending(dap), .wink_msg(wnk));
  // ****************************************************************
  // Bus cycles and comparison
  // ****************************************************************
  task automatic results;
    if (fail_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic bound(input int k);
    if (k >= 64)
    begin
      fail_count++;
      results();
    end
  endtask : bound
  task automatic chk(input string s, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", s, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    n = 0;
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awy) awv <= 1'b0;
      if (wy) wv <= 1'b0;
      n++;
    end
    while (bv !== 1'b1 && n < 64);
    bound(n);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    n = 0;
    ar <= a;
    arv <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (ary) arv <= 1'b0;
      n++;
    end
    while (rv !== 1'b1 && n < 64);
    r = rd_q;
    bound(n);
  endtask : rd
  task automatic press;
    pv[8] <= 1'b1;
    repeat (6) @(posedge aclk);
    pv[8] <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask : press
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(evt_pkg::OFS_TIMEOUT);
    chk("timeout", r, 32'h0a0a);
    rd(12'hffc);
    chk("decerr", rresp, evt_pkg::RESP_DECERR);
    pv[6] <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("alarm id", did, 5'd10);
    chk("ack mark", dap, 1'b1);
    pv[7] <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("newer id", did, 5'd13);
    chk("no drive", drv, 1'b0);
    rd(evt_pkg::OFS_STATUS);
    chk("hist count", r[11:6], 6'd1);
    pv[7:6] <= 2'b00;
    press();
    chk("disp clear", dv, 1'b0);
    pv[11] <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("emerg", emg, 1'b1);
    pv[11] <= 1'b0;
    repeat (3)
    begin
      k = anns;
      wr(evt_pkg::OFS_SEQ, {24'h0, seq ^ (8'($random(seed)) | 8'h01)});
      repeat (6) @(posedge aclk);
      chk("announce", anns - k, 1);
    end
    wr(evt_pkg::OFS_CTRL, 32'h2);
    wr(evt_pkg::OFS_NTHRESH, $random(seed) & 32'h7fff);
    rd(evt_pkg::OFS_NTHRESH);
    amps <= r[15:0] + 16'h1;
    repeat (8) @(posedge aclk);
    rd(evt_pkg::OFS_ACTIVE);
    chk("neutral", r[evt_pkg::EV_NEUTRAL], 1'b1);
    wr(evt_pkg::OFS_TIMEOUT, 32'h0202);
    pv[2] <= 1'b1;
    repeat (60) @(posedge aclk);
    rd(evt_pkg::OFS_ACTIVE);
    chk("xfer ok", {pos_a, r[evt_pkg::EV_FAIL_XFER]}, 2'b10);
    stuck <= 1'b1;
    pv[3] <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(evt_pkg::OFS_ACTIVE);
    chk("rexfer early", r[evt_pkg::EV_FAIL_REXFER], 1'b0);
    repeat (60) @(posedge aclk);
    rd(evt_pkg::OFS_ACTIVE);
    chk("rexfer fail", r[evt_pkg::EV_FAIL_REXFER], 1'b1);
    wr(evt_pkg::OFS_CTRL, 32'h3);
    pv[5:4] <= 2'b01;
    repeat (1150) @(posedge aclk);
    chk("sync early", sfr, 1'b0);
    repeat (150) @(posedge aclk);
    chk("sync fail", {sfr, opt}, 2'b11);
    pv[4] <= 1'b0;
    press();
    chk("sync clear", sfr, 1'b0);
    rd(evt_pkg::OFS_ACTIVE);
    chk("faults clear", r[6:0], 7'h00);
    pv[10:9] <= 2'b11;
    repeat (4) @(posedge aclk);
    chk("wink", wnk, 1'b1);
    chk("save", {sdn, sav, poff}, 3'b110);
    @(posedge aclk);
    chk("power off", {sav, poff}, 2'b01);
    results();
  end
endmodule : testbench
